// File: rtl/nested_ctx_regs.vh
// register offsets, field positions and reset values of the nested interrupt context block
`ifndef NESTED_CTX_REGS_VH
`define NESTED_CTX_REGS_VH
`define OFF_CTRL 8'h00
`define OFF_PERMIT 8'h04
`define OFF_REQ 8'h08
`define OFF_ADDR_REG 8'h0C
`define OFF_EVT_STATUS 8'h10
`define OFF_EVT_MASK 8'h14
`define OFF_DEPTH 8'h18
`define CTRL_GIE_BIT 0
`define CTRL_IXE_BIT 1
`define CTRL_BANK_LSB 4
`define CTRL_BANK_MSB 7
`define BANK_W 4
`define BANK_ZERO 4'h0
`define PC_W 13
`define PC_ZERO 13'h0000
`define NUM_SRC 5
`define SRC_ZERO 5'h00
`define SRC_CODE_W 3
`define SRC_EXT_A 3'h0
`define SRC_EXT_B 3'h1
`define SRC_TIMER 3'h2
`define SRC_SERIAL1 3'h3
`define SRC_FREQ_CNT 3'h4
`define RAS_DEPTH 7
`define RAS_CNT_W 3
`define CTX_DEPTH 4
`define CTX_CNT_W 3
`define CTX_W 5
`define NUM_EVT 4
`define EVT_ZERO 4'h0
`define EVT_RAS_OVF 0
`define EVT_RAS_UNF 1
`define EVT_CTX_OVF 2
`define EVT_CTX_UNF 3
`define DEPTH_RAS_LSB 0
`define DEPTH_CTX_LSB 8
`define WORD_ZERO 32'h00000000
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'h0
`endif

// File: rtl/nested_interrupt_context_stacks.v
// interrupt acceptance with context stack, shared return-address stack and ahb-lite registers
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "nested_ctx_regs.vh"
module nested_interrupt_context_stacks (
	input wire clk_sys,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire ext_irq_pin_a,
	input wire ext_irq_pin_b,
	input wire timer_evt,
	input wire serial1_evt,
	input wire freq_cnt_evt,
	input wire instr_boundary,
	input wire [`PC_W-1:0] ret_addr_in,
	input wire call_instr,
	input wire ret_instr,
	input wire return_from_interrupt_instr,
	input wire stack_pop_instr,
	input wire stack_push_instr,
	output reg irq_accept_r,
	output reg [`SRC_CODE_W-1:0] irq_source_r,
	output reg pc_load_r,
	output reg [`PC_W-1:0] pc_value_r,
	output wire [`BANK_W-1:0] bank,
	output wire index_enable_flag,
	output wire irq
);
	function [`SRC_CODE_W-1:0] first_src;
		input [`NUM_SRC-1:0] v;
		begin
			if (v[`SRC_EXT_A])
				first_src = `SRC_EXT_A;
			else if (v[`SRC_EXT_B])
				first_src = `SRC_EXT_B;
			else if (v[`SRC_TIMER])
				first_src = `SRC_TIMER;
			else if (v[`SRC_SERIAL1])
				first_src = `SRC_SERIAL1;
			else
				first_src = `SRC_FREQ_CNT;
		end
	endfunction

	// pin synchronisers and rising edge detect
	reg [1:0] pin_a_sync_r;
	reg [1:0] pin_b_sync_r;
	reg pin_a_last_r;
	reg pin_b_last_r;
	wire pin_a_rise;
	wire pin_b_rise;

	reg gie_r;
	reg ixe_r;
	reg [`BANK_W-1:0] bank_r;
	reg [`NUM_SRC-1:0] permit_r;
	reg [`NUM_SRC-1:0] req_r;
	reg [`NUM_SRC-1:0] req_nxt;
	reg [`PC_W-1:0] addr_reg_r;
	reg [`NUM_EVT-1:0] evt_status_r;
	reg [`NUM_EVT-1:0] evt_mask_r;

	// ahb data phase state
	reg wr_pend_r;
	reg [7:0] wr_addr_r;
	reg rd_clear_r;
	reg [`NUM_EVT-1:0] rd_evt_r;

	wire [`NUM_SRC-1:0] src_evt;
	wire [`NUM_SRC-1:0] pending;
	wire accept_go;
	wire do_return_from_interrupt_instr;
	wire do_ret;
	wire do_call;
	wire do_spop;
	wire do_spush;
	wire ras_push;
	wire ras_pop;
	wire [`PC_W-1:0] ras_din;
	wire [`PC_W-1:0] ras_top;
	wire [`RAS_CNT_W-1:0] ras_count;
	wire ras_ovf;
	wire ras_unf;
	wire [`CTX_W-1:0] ctx_top;
	wire [`CTX_CNT_W-1:0] ctx_count;
	wire ctx_ovf;
	wire ctx_unf;
	wire [`NUM_EVT-1:0] evt_now;
	wire addr_phase;
	wire wr_go;
	wire [7:0] ahb_off;
	reg [31:0] rd_word;

	assign pin_a_rise = pin_a_sync_r[1] && !pin_a_last_r;
	assign pin_b_rise = pin_b_sync_r[1] && !pin_b_last_r;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_a_sync_r <= 2'h0;
			pin_b_sync_r <= 2'h0;
			pin_a_last_r <= 1'b0;
			pin_b_last_r <= 1'b0;
		end else begin
			pin_a_sync_r <= {pin_a_sync_r[0], ext_irq_pin_a};
			pin_b_sync_r <= {pin_b_sync_r[0], ext_irq_pin_b};
			pin_a_last_r <= pin_a_sync_r[1];
			pin_b_last_r <= pin_b_sync_r[1];
		end
	end

	assign src_evt = {freq_cnt_evt, serial1_evt, timer_evt, pin_b_rise, pin_a_rise};
	assign pending = req_r & permit_r;

	// one operation per stack per cycle; acceptance has priority over instruction requests
	assign accept_go = instr_boundary && gie_r && (|pending);
	assign do_return_from_interrupt_instr = !accept_go && return_from_interrupt_instr;
	assign do_ret = !accept_go && !return_from_interrupt_instr && ret_instr;
	assign do_call = !accept_go && !return_from_interrupt_instr && !ret_instr && call_instr;
	assign do_spop = !accept_go && !return_from_interrupt_instr && !ret_instr && !call_instr && stack_pop_instr;
	assign do_spush = !accept_go && !return_from_interrupt_instr && !ret_instr && !call_instr && !stack_pop_instr &&
		stack_push_instr;

	assign ras_push = accept_go || do_call || do_spush;
	assign ras_din = do_spush ? addr_reg_r : ret_addr_in;
	assign ras_pop = do_return_from_interrupt_instr || do_ret || do_spop;

	shift_stack #(
		.W(`PC_W),
		.D(`RAS_DEPTH),
		.CW(`RAS_CNT_W)
	) u_return_address_stack (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.push(ras_push),
		.pop(ras_pop),
		.din(ras_din),
		.top(ras_top),
		.count_r(ras_count),
		.overflow_r(ras_ovf),
		.underflow_r(ras_unf)
	);

	shift_stack #(
		.W(`CTX_W),
		.D(`CTX_DEPTH),
		.CW(`CTX_CNT_W)
	) u_context_stack (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.push(accept_go),
		.pop(do_return_from_interrupt_instr),
		.din({bank_r, ixe_r}),
		.top(ctx_top),
		.count_r(ctx_count),
		.overflow_r(ctx_ovf),
		.underflow_r(ctx_unf)
	);

	// ahb-lite slave, zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = `HRESP_OKAY;
	assign addr_phase = hsel && htrans[`HTRANS_NONSEQ_BIT] && hready;
	assign ahb_off = haddr[7:0];
	assign wr_go = wr_pend_r;

	always @* begin
		rd_word = `WORD_ZERO;
		case (ahb_off)
			`OFF_CTRL: begin
				rd_word[`CTRL_GIE_BIT] = gie_r;
				rd_word[`CTRL_IXE_BIT] = ixe_r;
				rd_word[`CTRL_BANK_MSB:`CTRL_BANK_LSB] = bank_r;
			end
			`OFF_PERMIT: begin
				rd_word[`NUM_SRC-1:0] = permit_r;
			end
			`OFF_REQ: begin
				rd_word[`NUM_SRC-1:0] = req_r;
			end
			`OFF_ADDR_REG: begin
				rd_word[`PC_W-1:0] = addr_reg_r;
			end
			`OFF_EVT_STATUS: begin
				rd_word[`NUM_EVT-1:0] = evt_status_r;
			end
			`OFF_EVT_MASK: begin
				rd_word[`NUM_EVT-1:0] = evt_mask_r;
			end
			`OFF_DEPTH: begin
				rd_word[`DEPTH_RAS_LSB+`RAS_CNT_W-1:`DEPTH_RAS_LSB] = ras_count;
				rd_word[`DEPTH_CTX_LSB+`CTX_CNT_W-1:`DEPTH_CTX_LSB] = ctx_count;
			end
			default: begin
				rd_word = `WORD_ZERO;
			end
		endcase
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rd_clear_r <= 1'b0;
			rd_evt_r <= `EVT_ZERO;
			hrdata <= `WORD_ZERO;
		end else begin
			wr_pend_r <= addr_phase && hwrite;
			rd_clear_r <= addr_phase && !hwrite && (ahb_off == `OFF_EVT_STATUS);
			rd_evt_r <= evt_status_r;
			if (addr_phase) begin
				wr_addr_r <= ahb_off;
			end
			if (addr_phase && !hwrite) begin
				hrdata <= rd_word;
			end
		end
	end

	// request flags: hardware only sets, software writes one to clear, set wins
	always @* begin
		req_nxt = req_r & ~((wr_go && (wr_addr_r == `OFF_REQ)) ? hwdata[`NUM_SRC-1:0] : `SRC_ZERO);
		req_nxt = req_nxt | src_evt;
	end

	assign evt_now = {ctx_unf, ctx_ovf, ras_unf, ras_ovf};

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gie_r <= 1'b0;
			ixe_r <= 1'b0;
			bank_r <= `BANK_ZERO;
			permit_r <= `SRC_ZERO;
			req_r <= `SRC_ZERO;
			addr_reg_r <= `PC_ZERO;
			evt_status_r <= `EVT_ZERO;
			evt_mask_r <= `EVT_ZERO;
			irq_accept_r <= 1'b0;
			irq_source_r <= `SRC_EXT_A;
			pc_load_r <= 1'b0;
			pc_value_r <= `PC_ZERO;
		end else begin
			req_r <= req_nxt;
			irq_accept_r <= accept_go;
			pc_load_r <= do_return_from_interrupt_instr || do_ret;
			if (accept_go) begin
				irq_source_r <= first_src(pending);
			end
			if (do_return_from_interrupt_instr || do_ret) begin
				pc_value_r <= ras_top;
			end
			// read of the status register clears the bits it returned; a new event wins
			evt_status_r <= (evt_status_r & ~(rd_clear_r ? rd_evt_r : `EVT_ZERO)) | evt_now;
			if (wr_go && (wr_addr_r == `OFF_PERMIT)) begin
				permit_r <= hwdata[`NUM_SRC-1:0];
			end
			if (wr_go && (wr_addr_r == `OFF_EVT_MASK)) begin
				evt_mask_r <= hwdata[`NUM_EVT-1:0];
			end
			if (do_spop) begin
				addr_reg_r <= ras_top;
			end else if (wr_go && (wr_addr_r == `OFF_ADDR_REG)) begin
				addr_reg_r <= hwdata[`PC_W-1:0];
			end
			if (accept_go) begin
				bank_r <= `BANK_ZERO;
				ixe_r <= 1'b0;
				gie_r <= 1'b0;
			end else if (do_return_from_interrupt_instr) begin
				bank_r <= ctx_top[`CTX_W-1:1];
				ixe_r <= ctx_top[0];
			end else if (wr_go && (wr_addr_r == `OFF_CTRL)) begin
				gie_r <= hwdata[`CTRL_GIE_BIT];
				ixe_r <= hwdata[`CTRL_IXE_BIT];
				bank_r <= hwdata[`CTRL_BANK_MSB:`CTRL_BANK_LSB];
			end
		end
	end

	assign bank = bank_r;
	assign index_enable_flag = ixe_r;
	assign irq = |(evt_status_r & evt_mask_r);
endmodule // nested_interrupt_context_stacks

// File: rtl/shift_stack.v
// non-rotating shift stack: push drops the oldest entry when full, pop keeps the bottom entry
`timescale 1ns/10ps
module shift_stack #(
	parameter W = 13,
	parameter D = 7,
	parameter CW = 3
) (
	input wire clk_sys,
	input wire rst_n,
	input wire push,
	input wire pop,
	input wire [W-1:0] din,
	output wire [W-1:0] top,
	output reg [CW-1:0] count_r,
	output reg overflow_r,
	output reg underflow_r
);
	localparam [CW-1:0] FULL = D;
	localparam [CW-1:0] ONE = 1;
	localparam [CW-1:0] NONE = 0;
	reg [W-1:0] mem [0:D-1];
	integer i;

	assign top = mem[0];

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < D; i = i + 1) begin
				mem[i] <= {W{1'b0}};
			end
			count_r <= NONE;
			overflow_r <= 1'b0;
			underflow_r <= 1'b0;
		end else begin
			overflow_r <= push && (count_r == FULL);
			underflow_r <= pop && !push && (count_r == NONE);
			if (push) begin
				// oldest entry falls off the bottom once all entries are in use
				mem[0] <= din;
				for (i = 1; i < D; i = i + 1) begin
					mem[i] <= mem[i-1];
				end
				if (count_r != FULL) begin
					count_r <= count_r + ONE;
				end
			end else if (pop) begin
				// bottom entry is kept, so an excess return after the stack has been filled gets the deepest saved value again
				for (i = 0; i < D - 1; i = i + 1) begin
					mem[i] <= mem[i+1];
				end
				if (count_r != NONE) begin
					count_r <= count_r - ONE;
				end
			end
		end
	end
endmodule // shift_stack

// File: verification/nested_ctx_assertions.sv
// assertion checker for the nested interrupt context block
`timescale 1ns/10ps
module nested_ctx_checker (
	input wire clk_sys,
	input wire rst_n,
	input wire hreadyout,
	input wire hresp,
	input wire instr_boundary,
	input wire ret_instr,
	input wire return_from_interrupt_instr,
	input wire irq_accept_r,
	input wire [2:0] irq_source_r,
	input wire pc_load_r,
	input wire [12:0] pc_value_r,
	input wire [3:0] bank,
	input wire index_enable_flag
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_return_from_interrupt_instr;
		return_from_interrupt_instr && !instr_boundary;
	endsequence
	sequence s_ret;
		ret_instr && !return_from_interrupt_instr && !instr_boundary;
	endsequence
	AST_BUS_OK: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	AST_ACC_CLEAR: assert property (irq_accept_r |-> bank == 4'h0 && !index_enable_flag)
		else $error("context not cleared on accept");
	AST_ACC_CAUSE: assert property (irq_accept_r |-> $past(instr_boundary))
		else $error("accept outside instruction boundary");
	AST_ACC_PULSE: assert property (irq_accept_r |=> !irq_accept_r)
		else $error("accept pulse too long");
	AST_SRC: assert property (irq_accept_r |-> irq_source_r < 3'h5)
		else $error("source code out of range");
	AST_LOAD_CAUSE: assert property (pc_load_r |-> $past(ret_instr) || $past(return_from_interrupt_instr))
		else $error("pc load without return");
	AST_RETURN_FROM_INTERRUPT_INSTR: assert property (s_return_from_interrupt_instr |=> pc_load_r)
		else $error("interrupt return did not load pc");
	AST_RET_KEEP: assert property (s_ret |=> pc_load_r && $stable(bank) && $stable(index_enable_flag))
		else $error("plain return touched context");
	AST_PC_HOLD: assert property (!pc_load_r |-> $stable(pc_value_r))
		else $error("pc value moved without load");
endmodule // nested_ctx_checker
bind nested_interrupt_context_stacks nested_ctx_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
	.hreadyout(hreadyout), .hresp(hresp), .instr_boundary(instr_boundary), .ret_instr(ret_instr),
	.return_from_interrupt_instr(return_from_interrupt_instr), .irq_accept_r(irq_accept_r),
	.irq_source_r(irq_source_r), .pc_load_r(pc_load_r), .pc_value_r(pc_value_r), .bank(bank),
	.index_enable_flag(index_enable_flag));

// File: verification/nested_interrupt_context_stacks_tb_top.sv
// self-checking bench for the nested interrupt context block
`timescale 1ns/10ps
`define CHK(a,b) begin checked++; if ((a) !== (b)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module nested_interrupt_context_stacks_tb_top;
	logic clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, ib = 0;
	logic hreadyout, hresp, irq_accept_r, pc_load_r, index_enable_flag, irq;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, seed = 32'h2366;
	logic [1:0] htrans = 0;
	logic [4:0] src = 0, ops = 0;
	logic [12:0] ra = 0, pc_value_r;
	logic [2:0] irq_source_r;
	logic [3:0] bank, b;
	int fail_count = 0, checked = 0, cyc = 0, i, k, n;
	nested_interrupt_context_stacks dut_u (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.ext_irq_pin_a(src[0]), .ext_irq_pin_b(src[1]), .timer_evt(src[2]), .serial1_evt(src[3]),
		.freq_cnt_evt(src[4]), .instr_boundary(ib), .ret_addr_in(ra), .call_instr(ops[4]),
		.ret_instr(ops[3]), .return_from_interrupt_instr(ops[2]), .stack_pop_instr(ops[1]),
		.stack_push_instr(ops[0]), .irq_accept_r, .irq_source_r, .pc_load_r, .pc_value_r, .bank,
		.index_enable_flag, .irq);
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	function automatic [31:0] lf(input [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic ahb(input w, input [7:0] a, input [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge clk_sys);
		while (hreadyout !== 1'h1) @(posedge clk_sys);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'h1) @(posedge clk_sys);
		rd = hrdata;
		#1;
	endtask
	task automatic cpu(input [4:0] v);
		@(posedge clk_sys);
		ops <= v;
		ib <= 1'h0;
		@(posedge clk_sys);
		ops <= 5'h00;
		#1;
	endtask
	task automatic trig(input [4:0] s);
		@(posedge clk_sys);
		src <= s;
		ib <= 1'h1;
		@(posedge clk_sys);
		src <= src & 5'h03;
		#1;
		for (n = 0; n < 20 && irq_accept_r !== 1'h1; n++) @(posedge clk_sys) #1;
		ib <= 1'h0;
		`CHK(irq_accept_r, 1'h1)
		`CHK(bank, 4'h0)
		`CHK(index_enable_flag, 1'h0)
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			final_report;
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'h1;
		ahb(1, 8'h04, 32'h1F);
		ahb(1, 8'h14, 32'hF);
		// save area at 40H and above lies outside the register map and must not alias a register
		ahb(1, 8'h40, 32'hFF);
		ahb(0, 8'h40, 32'h0);
		`CHK(rd, 32'h0)
		// every source once, random context and return address
		for (i = 0; i < 5; i++) begin
			seed = lf(seed);
			b = seed[7:4];
			ra <= seed[20:8];
			ahb(1, 8'h00, {24'h0, b, 2'h0, seed[1], 1'h1});
			trig(5'h01 << i);
			`CHK(irq_source_r, i[2:0])
			ahb(0, 8'h08, 32'h0);
			`CHK(rd, 32'h1 << i)
			ahb(1, 8'h08, 32'h1 << i);
			cpu(5'h04);
			`CHK(pc_load_r, 1'h1)
			`CHK(pc_value_r, seed[20:8])
			`CHK({bank, index_enable_flag}, {b, seed[1]})
		end
		// five nested accepts, timer request left pending
		for (k = 1; k < 6; k++) begin
			ra <= k[12:0];
			ahb(1, 8'h00, {24'h0, k[3:0], 2'h0, k[0], 1'h1});
			trig(k == 1 ? 5'h04 : 5'h00);
		end
		ahb(0, 8'h18, 32'h0);
		`CHK(rd, 32'h405)
		for (k = 5; k > 0; k--) begin
			n = (k > 1) ? k : 2;
			cpu(5'h04);
			`CHK({bank, index_enable_flag}, {n[3:0], n[0]})
			`CHK(pc_value_r, k[12:0])
		end
		// outermost handler: lower sources off, own context set by hand, plain return
		ahb(1, 8'h00, 32'h61);
		trig(5'h00);
		ahb(1, 8'h04, 32'h3);
		ahb(1, 8'h00, 32'h93);
		ib <= 1'h1;
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK(irq_accept_r, 1'h0)
		cpu(5'h08);
		`CHK({bank, index_enable_flag}, 5'h13)
		`CHK(pc_value_r, 13'h5)
		ahb(1, 8'h08, 32'h4);
		ahb(0, 8'h10, 32'h0);
		`CHK(rd, 32'hC)
		// eight calls overflow the seven-entry address stack
		for (k = 0; k < 8; k++) begin
			ra <= 13'h100 + k[12:0];
			cpu(5'h10);
		end
		// overflow flag registers one cycle after the push, status one more
		@(posedge clk_sys);
		#1;
		`CHK(irq, 1'h1)
		ahb(1, 8'h14, 32'h0);
		`CHK(irq, 1'h0)
		ahb(1, 8'h14, 32'hF);
		`CHK(irq, 1'h1)
		ahb(0, 8'h10, 32'h0);
		`CHK(rd, 32'h1)
		`CHK(irq, 1'h0)
		for (k = 7; k >= 0; k--) begin
			cpu(5'h08);
			`CHK(pc_value_r, 13'h100 + (k > 0 ? k : 1))
		end
		ahb(0, 8'h10, 32'h0);
		`CHK(rd, 32'h2)
		// address moved out to the address register and back
		ra <= 13'h0AB;
		cpu(5'h10);
		cpu(5'h02);
		ahb(0, 8'h0C, 32'h0);
		`CHK(rd, 32'hAB)
		ahb(1, 8'h0C, 32'h123);
		cpu(5'h01);
		cpu(5'h08);
		`CHK(pc_value_r, 13'h123)
		final_report;
	end
endmodule // nested_interrupt_context_stacks_tb_top
